// >>> efh_frame_field.sv
// ethernet frame field handler: tx framing, rx stripping and checks, apb registers
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
module efh_frame_field
   import efh_pkg::*;
#(
   parameter int CNT_W = 16,
   parameter int ADDR_W = 8
)
(
   input wire logic SYS_CLK_I,
   input wire logic RST_I,
   input wire logic CE_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [ADDR_W-1:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   input wire logic [7:0] TX_DATA_I,
   input wire logic TX_VALID_I,
   input wire logic TX_LAST_I,
   output logic TX_READY_O,
   output logic [7:0] TXD_O,
   output logic TX_EN_O,
   input wire logic [7:0] RXD_I,
   input wire logic RX_DV_I,
   output logic [7:0] RX_DATA_O,
   output logic RX_VALID_O,
   output logic RX_LAST_O,
   output logic RX_BAD_O
);
   typedef enum logic [2:0] {TX_IDLE, TX_PRE, TX_SFD, TX_DATA, TX_PAD, TX_FCS} efh_tx_e;
   typedef enum logic [1:0] {RX_IDLE, RX_PRE, RX_BODY, RX_DROP} efh_rx_e;

   localparam logic [CNT_W-1:0] TX_PAD_END = CNT_W'(MIN_FRAME - FCS_BYTES);
   localparam logic [CNT_W-1:0] MIN_FRAME_C = CNT_W'(MIN_FRAME);
   localparam logic [CNT_W-1:0] HDR_C = CNT_W'(HDR_BYTES);
   localparam logic [CNT_W-1:0] OVERHEAD_C = CNT_W'(HDR_BYTES + FCS_BYTES);
   localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

   // register file
   logic [CTRL_W-1:0] ctrl_q;
   logic [15:0] maxlen_q;
   logic [ST_W-1:0] status_q;
   logic [15:0] good_cnt_q, bad_cnt_q;
   logic pready_q, pslverr_q;
   logic [31:0] prdata_q;

   wire logic tx_cust = ctrl_q[CTRL_TX_CUST_PRE];
   wire logic tx_pass = ctrl_q[CTRL_TX_FCS_PASS];
   wire logic rx_cust = ctrl_q[CTRL_RX_CUST_PRE];
   wire logic rx_pass = ctrl_q[CTRL_RX_FCS_PASS];

   wire logic sel_ctrl = PADDR_I == ADDR_W'(REG_CTRL_OFS);
   wire logic sel_max = PADDR_I == ADDR_W'(REG_MAXLEN_OFS);
   wire logic sel_stat = PADDR_I == ADDR_W'(REG_STATUS_OFS);
   wire logic sel_cnt = PADDR_I == ADDR_W'(REG_COUNT_OFS);
   wire logic sel_any = sel_ctrl | sel_max | sel_stat | sel_cnt;
   wire logic apb_setup = PSEL_I & PENABLE_I & ~pready_q;
   wire logic apb_done = PSEL_I & PENABLE_I & pready_q;
   wire logic wr_ctrl = apb_done & PWRITE_I & sel_ctrl;
   wire logic wr_max = apb_done & PWRITE_I & sel_max;
   wire logic wr_cnt = apb_done & PWRITE_I & sel_cnt;
   wire logic [31:0] rd_mux = sel_ctrl ? 32'(ctrl_q) :
                              sel_max ? 32'(maxlen_q) :
                              sel_stat ? 32'(status_q) :
                              sel_cnt ? {bad_cnt_q, good_cnt_q} : 32'h00000000;

   assign PRDATA_O = prdata_q;
   assign PREADY_O = pready_q;
   assign PSLVERR_O = pslverr_q;

   // one wait state: answer rises on the first edge of the access phase, transfer completes on the second
   always_ff @(posedge SYS_CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h00000000;
         ctrl_q <= CTRL_RESET;
         maxlen_q <= MAXLEN_RESET;
      end
      else if (CE_I)
      begin
         pready_q <= apb_setup;
         pslverr_q <= apb_setup & ~sel_any;
         prdata_q <= (apb_setup & ~PWRITE_I) ? rd_mux : 32'h00000000;
         if (wr_ctrl)
            ctrl_q <= PWDATA_I[CTRL_W-1:0];
         if (wr_max)
            maxlen_q <= PWDATA_I[15:0];
      end
   end

   // transmit path
   efh_tx_e tx_state_q, tx_state_d;
   logic [2:0] tx_sub_q;
   logic [CNT_W-1:0] tx_len_q;
   logic [7:0] txd_q;
   logic tx_en_q, tx_ready_q;
   logic [31:0] tx_crc;

   wire logic tx_take = tx_ready_q & TX_VALID_I;
   wire logic [CNT_W-1:0] tx_len_inc = (tx_len_q == CNT_MAX) ? tx_len_q : tx_len_q + 1'b1;
   wire logic tx_short = tx_len_inc < (tx_pass ? MIN_FRAME_C : TX_PAD_END);
   // complemented remainder, low byte first puts order 31 first on the line
   wire logic [31:0] tx_fcs = ~tx_crc;
   wire logic [7:0] tx_fcs_byte = tx_fcs[8*tx_sub_q[1:0] +: 8];
   wire logic tx_crc_init = tx_state_q == TX_IDLE;
   wire logic tx_crc_en = (tx_state_q == TX_DATA && tx_take) ||
                          (tx_state_q == TX_PAD && !tx_pass);
   // pad enters the check as zeros, never the stale client byte still on the input
   wire logic [7:0] tx_crc_byte = (tx_state_q == TX_PAD) ? PAD_BYTE : TX_DATA_I;

   always_comb
   begin
      tx_state_d = tx_state_q;
      case (tx_state_q)
         TX_IDLE:
            if (TX_VALID_I)
               tx_state_d = TX_PRE;
         TX_PRE:
            if (tx_sub_q == PRE_LAST)
               tx_state_d = TX_SFD;
         TX_SFD:
            if (!tx_cust || tx_take)
               tx_state_d = TX_DATA;
         TX_DATA:
            if (tx_take && TX_LAST_I)
            begin
               // pad after a client fcs still keeps the line frame long enough
               if (tx_short)
                  tx_state_d = TX_PAD;
               else
                  tx_state_d = tx_pass ? TX_IDLE : TX_FCS;
            end
         TX_PAD:
            if (!tx_short)
               tx_state_d = tx_pass ? TX_IDLE : TX_FCS;
         TX_FCS:
            if (tx_sub_q[1:0] == FCS_LAST)
               tx_state_d = TX_IDLE;
         default:
            tx_state_d = TX_IDLE;
      endcase
   end

   always_ff @(posedge SYS_CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         tx_state_q <= TX_IDLE;
         tx_sub_q <= 3'h0;
         tx_len_q <= '0;
         txd_q <= PAD_BYTE;
         tx_en_q <= 1'b0;
         tx_ready_q <= 1'b0;
      end
      else if (CE_I)
      begin
         tx_state_q <= tx_state_d;
         tx_ready_q <= (tx_state_d == TX_DATA && !(tx_take && TX_LAST_I)) ||
                       (tx_state_d == TX_SFD && tx_cust && tx_state_q != TX_SFD);
         tx_sub_q <= (tx_state_d != tx_state_q) ? 3'h0 : tx_sub_q + 3'h1;
         case (tx_state_q)
            TX_PRE:
            begin
               txd_q <= PRE_BYTE;
               tx_en_q <= 1'b1;
            end
            TX_SFD:
            begin
               txd_q <= tx_cust ? TX_DATA_I : SFD_BYTE;
               tx_en_q <= !tx_cust || tx_take;
               tx_len_q <= '0;
            end
            TX_DATA:
            begin
               // da, sa and length/type leave exactly as the client gave them
               txd_q <= TX_DATA_I;
               tx_en_q <= tx_take;
               if (tx_take)
                  tx_len_q <= tx_len_inc;
            end
            TX_PAD:
            begin
               txd_q <= PAD_BYTE;
               tx_en_q <= 1'b1;
               tx_len_q <= tx_len_inc;
            end
            TX_FCS:
            begin
               txd_q <= tx_fcs_byte;
               tx_en_q <= 1'b1;
            end
            default:
            begin
               txd_q <= PAD_BYTE;
               tx_en_q <= 1'b0;
            end
         endcase
      end
   end

   efh_crc u_tx_crc (
      .clk_i(SYS_CLK_I),
      .rst_i(RST_I),
      .ce_i(CE_I),
      .init_i(tx_crc_init),
      .en_i(tx_crc_en),
      .data_i(tx_crc_byte),
      .crc_o(tx_crc)
   );

   assign TXD_O = txd_q;
   assign TX_EN_O = tx_en_q;
   assign TX_READY_O = tx_ready_q;

   // receive path
   efh_rx_e rx_state_q, rx_state_d;
   logic [2:0] rx_sub_q;
   logic [CNT_W-1:0] rx_cnt_q;
   logic [3:0][7:0] dly_q;
   logic [2:0] dly_n_q;
   logic [15:0] lt_q;
   logic grp_q, bc_q;
   logic [7:0] pend_q;
   logic pend_v_q;
   logic [7:0] rx_data_q;
   logic rx_valid_q, rx_last_q, rx_bad_q;
   logic [31:0] rx_crc;

   wire logic rx_in_body = rx_state_q == RX_BODY;
   wire logic rx_byte = rx_in_body & RX_DV_I;
   wire logic rx_end = rx_in_body & ~RX_DV_I;
   wire logic [CNT_W-1:0] rx_cnt_inc = (rx_cnt_q == CNT_MAX) ? rx_cnt_q : rx_cnt_q + 1'b1;
   // without fcs pass the last four bytes are held back, so output lags by four
   wire logic cand_v = rx_byte & (rx_pass | dly_n_q[2]);
   wire logic [7:0] cand = rx_pass ? RXD_I : dly_q[3];
   wire logic [CNT_W-1:0] cand_idx = rx_pass ? rx_cnt_q : rx_cnt_q - CNT_W'(FCS_BYTES);
   wire logic lt_is_type = lt_q >= TYPE_MIN;
   wire logic lt_vlan = lt_q == LT_VLAN;
   wire logic lt_pause = lt_q == LT_PAUSE;
   wire logic [CNT_W-1:0] lt_len = CNT_W'(lt_q);
   wire logic in_pad = !lt_is_type && cand_idx >= HDR_C && cand_idx >= HDR_C + lt_len;
   wire logic cand_keep = cand_v & ~(in_pad & ~rx_pass);
   wire logic fcs_err = rx_crc != CRC_RESIDUE;
   wire logic runt = rx_cnt_q < MIN_FRAME_C;
   wire logic len_err = !lt_is_type &&
                        (lt_q < 16'(MIN_DATA) ? rx_cnt_q != MIN_FRAME_C
                                              : rx_cnt_q - OVERHEAD_C != lt_len);
   wire logic [15:0] max_now = maxlen_q + ((lt_vlan && ctrl_q[CTRL_VLAN_EN]) ? 16'(VLAN_EXTRA) : 16'h0000);
   wire logic too_long = !ctrl_q[CTRL_JUMBO_EN] && rx_cnt_q > CNT_W'(max_now);
   wire logic frame_bad = fcs_err | (ctrl_q[CTRL_LEN_CHK] & len_err) | too_long | runt;

   always_comb
   begin
      rx_state_d = rx_state_q;
      case (rx_state_q)
         RX_IDLE:
            if (RX_DV_I)
               rx_state_d = (rx_cust || RXD_I == PRE_BYTE) ? RX_PRE : RX_DROP;
         RX_PRE:
            if (!RX_DV_I)
               rx_state_d = RX_IDLE;
            else if (rx_cust)
            begin
               if (rx_sub_q == PRE_SFD_POS)
                  rx_state_d = RX_BODY;
            end
            else if (RXD_I == SFD_BYTE)
               rx_state_d = RX_BODY;
            else if (RXD_I != PRE_BYTE)
               rx_state_d = RX_DROP;
         RX_BODY:
            if (!RX_DV_I)
               rx_state_d = RX_IDLE;
         RX_DROP:
            if (!RX_DV_I)
               rx_state_d = RX_IDLE;
         default:
            rx_state_d = RX_IDLE;
      endcase
   end

   always_ff @(posedge SYS_CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         rx_state_q <= RX_IDLE;
         rx_sub_q <= 3'h0;
         rx_cnt_q <= '0;
         dly_q <= '0;
         dly_n_q <= 3'h0;
         lt_q <= 16'h0000;
         grp_q <= 1'b0;
         bc_q <= 1'b0;
      end
      else if (CE_I)
      begin
         rx_state_q <= rx_state_d;
         rx_sub_q <= (rx_state_q == RX_IDLE) ? 3'h1 : rx_sub_q + 3'h1;
         if (rx_state_q != RX_BODY)
         begin
            rx_cnt_q <= '0;
            dly_n_q <= 3'h0;
            bc_q <= 1'b1;
         end
         else if (rx_byte)
         begin
            rx_cnt_q <= rx_cnt_inc;
            dly_q <= {dly_q[2:0], RXD_I};
            dly_n_q <= dly_n_q[2] ? dly_n_q : dly_n_q + 3'h1;
            if (rx_cnt_q == '0)
               grp_q <= RXD_I[0];
            if (rx_cnt_q < CNT_W'(DA_BYTES))
               bc_q <= bc_q & (&RXD_I);
            if (rx_cnt_q == CNT_W'(LT_HI_POS))
               lt_q[15:8] <= RXD_I;
            if (rx_cnt_q == CNT_W'(LT_LO_POS))
               lt_q[7:0] <= RXD_I;
         end
      end
   end

   // one byte is parked so the last kept byte can carry the end marker
   always_ff @(posedge SYS_CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         pend_q <= 8'h00;
         pend_v_q <= 1'b0;
         rx_data_q <= 8'h00;
         rx_valid_q <= 1'b0;
         rx_last_q <= 1'b0;
         rx_bad_q <= 1'b0;
      end
      else if (CE_I)
      begin
         rx_valid_q <= (cand_keep | rx_end) & pend_v_q;
         rx_last_q <= rx_end & pend_v_q;
         rx_bad_q <= rx_end & pend_v_q & frame_bad;
         if (pend_v_q && (cand_keep || rx_end))
            rx_data_q <= pend_q;
         if (cand_keep)
         begin
            pend_q <= cand;
            pend_v_q <= 1'b1;
         end
         else if (rx_end)
            pend_v_q <= 1'b0;
      end
   end

   // frame result capture; a frame ending in the same cycle as a counter clear is counted from zero
   always_ff @(posedge SYS_CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         status_q <= '0;
         good_cnt_q <= 16'h0000;
         bad_cnt_q <= 16'h0000;
      end
      else if (CE_I)
      begin
         if (rx_end)
         begin
            status_q[ST_GOOD] <= !frame_bad;
            status_q[ST_FCS_ERR] <= fcs_err;
            status_q[ST_LEN_ERR] <= len_err;
            status_q[ST_TOO_LONG] <= too_long;
            status_q[ST_RUNT] <= runt;
            status_q[ST_GROUP] <= grp_q;
            status_q[ST_BCAST] <= bc_q;
            status_q[ST_VLAN] <= lt_vlan;
            status_q[ST_PAUSE] <= lt_pause;
            status_q[ST_TYPE] <= lt_is_type;
         end
         good_cnt_q <= (wr_cnt ? 16'h0000 : good_cnt_q) + 16'(rx_end & ~frame_bad);
         bad_cnt_q <= (wr_cnt ? 16'h0000 : bad_cnt_q) + 16'(rx_end & frame_bad);
      end
   end

   efh_crc u_rx_crc (
      .clk_i(SYS_CLK_I),
      .rst_i(RST_I),
      .ce_i(CE_I),
      .init_i(!rx_in_body),
      .en_i(rx_byte),
      .data_i(RXD_I),
      .crc_o(rx_crc)
   );

   assign RX_DATA_O = rx_data_q;
   assign RX_VALID_O = rx_valid_q;
   assign RX_LAST_O = rx_last_q;
   assign RX_BAD_O = rx_bad_q;
endmodule

// >>> efh_pkg.sv
// constants shared by the frame field handler files
package efh_pkg;
   // apb register byte offsets
   localparam logic [7:0] REG_CTRL_OFS = 8'h00;
   localparam logic [7:0] REG_MAXLEN_OFS = 8'h04;
   localparam logic [7:0] REG_STATUS_OFS = 8'h08;
   localparam logic [7:0] REG_COUNT_OFS = 8'h0C;
   // control bit positions
   localparam int CTRL_TX_CUST_PRE = 0;
   localparam int CTRL_TX_FCS_PASS = 1;
   localparam int CTRL_RX_CUST_PRE = 2;
   localparam int CTRL_RX_FCS_PASS = 3;
   localparam int CTRL_LEN_CHK = 4;
   localparam int CTRL_VLAN_EN = 5;
   localparam int CTRL_JUMBO_EN = 6;
   localparam int CTRL_W = 7;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;
   localparam logic [15:0] MAXLEN_RESET = 16'h05EE;
   // status bit positions
   localparam int ST_GOOD = 0;
   localparam int ST_FCS_ERR = 1;
   localparam int ST_LEN_ERR = 2;
   localparam int ST_TOO_LONG = 3;
   localparam int ST_RUNT = 4;
   localparam int ST_GROUP = 5;
   localparam int ST_BCAST = 6;
   localparam int ST_VLAN = 7;
   localparam int ST_PAUSE = 8;
   localparam int ST_TYPE = 9;
   localparam int ST_W = 10;
   // frame field constants
   localparam logic [7:0] PRE_BYTE = 8'h55;
   localparam logic [7:0] SFD_BYTE = 8'hD5;
   localparam logic [7:0] PAD_BYTE = 8'h00;
   localparam logic [2:0] PRE_LAST = 3'h6;
   localparam logic [2:0] PRE_SFD_POS = 3'h7;
   localparam logic [1:0] FCS_LAST = 2'h3;
   localparam int FCS_BYTES = 4;
   localparam int HDR_BYTES = 14;
   localparam int LT_HI_POS = 12;
   localparam int LT_LO_POS = 13;
   localparam int DA_BYTES = 6;
   localparam int MIN_FRAME = 64;
   localparam int MIN_DATA = 46;
   localparam int VLAN_EXTRA = 4;
   localparam logic [15:0] TYPE_MIN = 16'h0600;
   localparam logic [15:0] LT_VLAN = 16'h8100;
   localparam logic [15:0] LT_PAUSE = 16'h8808;
   // reflected crc-32 constants
   localparam logic [31:0] CRC_POLY_REV = 32'hEDB88320;
   localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
   localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;
endpackage

// >>> efh_crc.sv
// byte-wide frame check engine, lsb-first reflected form
`timescale 1ns/1ps
module efh_crc
   import efh_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic init_i,
   input wire logic en_i,
   input wire logic [7:0] data_i,
   output logic [31:0] crc_o
);
   function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
      logic [31:0] r;
      r = c;
      for (int i = 0; i < 8; i++)
      begin
         r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY_REV) : (r >> 1);
      end
      return r;
   endfunction

   logic [31:0] crc_q;
   wire logic [31:0] crc_d = init_i ? CRC_INIT : crc_byte(crc_q, data_i);
   assign crc_o = crc_q;

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         crc_q <= CRC_INIT;
      else if (ce_i && (init_i || en_i))
         crc_q <= crc_d;
   end
endmodule

// >>> efh_frame_field_asserts.sv
// concurrent checks on the frame field handler ports
`timescale 1ns/1ps
module efh_ff_chk
   import efh_pkg::*;
(
   input wire logic SYS_CLK_I,
   input wire logic RST_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic [31:0] PRDATA_O,
   input wire logic PREADY_O,
   input wire logic PSLVERR_O,
   input wire logic [7:0] TX_DATA_I,
   input wire logic TX_VALID_I,
   input wire logic TX_READY_O,
   input wire logic [7:0] TXD_O,
   input wire logic TX_EN_O,
   input wire logic RX_DV_I,
   input wire logic RX_VALID_O,
   input wire logic RX_LAST_O,
   input wire logic RX_BAD_O
);
   logic [15:0] run_q;
   logic [15:0] run_d;
   // length of the current line burst, preamble included
   assign run_d = TX_EN_O ? run_q + 16'h0001 : 16'h0000;
   always_ff @(posedge SYS_CLK_I or posedge RST_I)
      if (RST_I)
         run_q <= 16'h0000;
      else
         run_q <= run_d;
   default clocking @(posedge SYS_CLK_I); endclocking
   default disable iff (RST_I);
   sequence s_pre;
      // custom mode raises ready with the last preamble byte for the replacement byte
      (TX_EN_O && TXD_O == PRE_BYTE && !TX_READY_O) [*6] ##1 (TX_EN_O && TXD_O == PRE_BYTE);
   endsequence
   sequence s_quiet;
      (!RX_VALID_O) [*8];
   endsequence
   AST_APB_WAIT: assert property ((PSEL_I && PENABLE_I && !PREADY_O) |=> PREADY_O)
      else $error("apb answer missing");
   AST_APB_PULSE: assert property (PREADY_O |=> !PREADY_O)
      else $error("pready longer than one cycle");
   AST_APB_IDLE: assert property (!PREADY_O |-> PRDATA_O == 32'h00000000)
      else $error("read data outside answer");
   AST_APB_ERR: assert property (PSLVERR_O |-> PREADY_O)
      else $error("pslverr without pready");
   AST_TX_PRE: assert property ($rose(TX_EN_O) |-> s_pre)
      else $error("preamble wrong");
   AST_TX_PASS: assert property ((TX_VALID_I && TX_READY_O) |=> (TX_EN_O && TXD_O == $past(TX_DATA_I)))
      else $error("client byte not passed");
   AST_TX_MIN: assert property ($fell(TX_EN_O) |-> run_q >= 16'h0048)
      else $error("frame on line too short");
   AST_RX_STRIP: assert property ($rose(RX_DV_I) |-> s_quiet)
      else $error("rx output during preamble");
   AST_RX_BAD: assert property (RX_BAD_O |-> (RX_LAST_O && RX_VALID_O))
      else $error("bad flag off frame end");
   AST_RX_LAST: assert property (RX_LAST_O |-> (!RX_DV_I && !$past(RX_DV_I)))
      else $error("frame end while line active");
endmodule
bind efh_frame_field efh_ff_chk u_chk (
   .SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PRDATA_O(PRDATA_O),
   .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .TX_DATA_I(TX_DATA_I), .TX_VALID_I(TX_VALID_I),
   .TX_READY_O(TX_READY_O), .TXD_O(TXD_O), .TX_EN_O(TX_EN_O), .RX_DV_I(RX_DV_I), .RX_VALID_O(RX_VALID_O),
   .RX_LAST_O(RX_LAST_O), .RX_BAD_O(RX_BAD_O)
);

// >>> efh_phy_loop.sv
// line side model: loops tx bytes back into rx, may corrupt one byte
`timescale 1ns/1ps
module efh_phy_loop
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] txd_i,
   input wire logic tx_en_i,
   input wire logic corrupt_i,
   output logic [7:0] rxd_o,
   output logic rx_dv_o
);
   logic [7:0] pos_q;
   always_ff @(posedge clk_i or posedge rst_i)
      if (rst_i)
      begin
         rx_dv_o <= 1'b0;
         rxd_o <= 8'h00;
         pos_q <= 8'h00;
      end
      else
      begin
         rx_dv_o <= tx_en_i;
         pos_q <= tx_en_i ? pos_q + 8'h01 : 8'h00;
         // idle line toggles so a stale byte never looks valid
         if (tx_en_i)
            rxd_o <= txd_i ^ ((corrupt_i && pos_q == 8'h1E) ? 8'h01 : 8'h00);
         else
            rxd_o <= ~rxd_o;
      end
endmodule

// >>> tb.sv
// self-checking bench: registers, tx framing and rx checks over a loopback line
`timescale 1ns/1ps
module tb
   import efh_pkg::*;
;
   typedef logic [7:0] efh_bq_t[$];
   logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, txv = 1'b0, txl = 1'b0, cor = 1'b0;
   logic [7:0] pa = 8'h00, txdi = 8'h00, txd, rxd, rd8;
   logic [31:0] pwd = 32'h00000000, prd, rdw;
   logic prdy, perr, txr, txe, rdv, rv, rl, rb, erw, badq, got;
   logic [7:0] ra[5] = '{REG_CTRL_OFS, REG_MAXLEN_OFS, REG_STATUS_OFS, REG_COUNT_OFS, 8'h10};
   logic [31:0] re[5] = '{32'(CTRL_RESET), 32'(MAXLEN_RESET), 32'h0, 32'h0, 32'h0};
   logic [15:0] lts[5] = '{16'h0000, TYPE_MIN, LT_VLAN, LT_PAUSE, 16'h0800};
   int n_mismatch = 0, checks = 0, cyc = 0, ngood = 0, nbad = 0, n;
   logic [15:0] lt;
   efh_bq_t lq, rq;
   always #5 clk = ~clk;
   efh_frame_field dut (
      .SYS_CLK_I(clk), .RST_I(rst), .CE_I(1'b1), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
      .PADDR_I(pa), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr),
      .TX_DATA_I(txdi), .TX_VALID_I(txv), .TX_LAST_I(txl), .TX_READY_O(txr), .TXD_O(txd), .TX_EN_O(txe),
      .RXD_I(rxd), .RX_DV_I(rdv), .RX_DATA_O(rd8), .RX_VALID_O(rv), .RX_LAST_O(rl), .RX_BAD_O(rb)
   );
   efh_phy_loop phy (.clk_i(clk), .rst_i(rst), .txd_i(txd), .tx_en_i(txe), .corrupt_i(cor), .rxd_o(rxd),
      .rx_dv_o(rdv));
   task automatic results();
      if (n_mismatch == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic cmpq(input string s, input efh_bq_t e, input efh_bq_t g);
      chk(s, e.size(), g.size());
      foreach (e[i])
         if (i < g.size())
            chk(s, 32'(e[i]), 32'(g[i]));
   endtask
   always @(posedge clk)
   begin
      cyc++;
      if (txe)
         lq.push_back(txd);
      if (rv)
         rq.push_back(rd8);
      if (rl)
         got = 1'b1;
      if (rl)
         badq = rb;
      if (cyc == 30000)
         chk("timeout", 32'h0, 32'h1);
      if (cyc == 30000)
         results();
   end
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
      output logic er);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (prdy !== 1'b1);
      r = prd;
      er = perr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask
   task automatic send(input efh_bq_t s);
      int i;
      i = 0;
      while (i < s.size())
      begin
         txdi <= s[i];
         txv <= 1'b1;
         txl <= (i == s.size() - 1);
         @(posedge clk);
         if (txr === 1'b1)
            i++;
      end
      txv <= 1'b0;
      txl <= 1'b0;
   endtask
   function automatic logic [31:0] crc32(input efh_bq_t q);
      logic [31:0] c;
      c = CRC_INIT;
      foreach (q[i])
      begin
         c ^= 32'(q[i]);
         repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY_REV : c >> 1;
      end
      return ~c;
   endfunction
   function automatic efh_bq_t mkf(input int dk, input logic [15:0] t, input int len);
      efh_bq_t f;
      for (int i = 0; i < 12 + len; i++)
         f.push_back(8'($urandom));
      f[0][0] = (dk != 0);
      for (int i = 0; i < DA_BYTES && dk == 2; i++)
         f[i] = 8'hFF;
      f.insert(LT_HI_POS, t[15:8]);
      f.insert(LT_LO_POS, t[7:0]);
      return f;
   endfunction
   task automatic run(input logic [6:0] ctl, input efh_bq_t f, input int eb);
      efh_bq_t p, el, er, s;
      logic [31:0] c, st, ex;
      logic [15:0] t;
      apb(1'b1, REG_CTRL_OFS, {25'h0, ctl}, st, erw);
      t = {f[LT_HI_POS], f[LT_LO_POS]};
      p = f;
      while (p.size() < MIN_FRAME - FCS_BYTES)
         p.push_back(PAD_BYTE);
      c = crc32(p);
      for (int i = 0; i < 7; i++)
         el.push_back(PRE_BYTE);
      el.push_back(ctl[CTRL_TX_CUST_PRE] ? 8'hA7 : SFD_BYTE);
      el = {el, p, c[7:0], c[15:8], c[23:16], c[31:24]};
      if (ctl[CTRL_RX_FCS_PASS])
         er = el[8:$];
      else if (t < TYPE_MIN)
         er = f;
      else
         er = p;
      if (ctl[CTRL_TX_FCS_PASS])
         s = el[8:$];
      else
         s = f;
      if (ctl[CTRL_TX_CUST_PRE])
         s.push_front(8'hA7);
      lq.delete();
      rq.delete();
      got = 1'b0;
      send(s);
      for (int k = 0; k < 400 && !got; k++)
         @(posedge clk);
      repeat (2) @(posedge clk);
      cmpq("line", el, lq);
      chk("rx bad", 32'(eb >= 0), 32'(badq));
      apb(1'b0, REG_STATUS_OFS, 32'h0, st, erw);
      ex = 32'h1 | (32'(f[0][0]) << ST_GROUP) | (32'({f[0], f[1], f[2], f[3], f[4], f[5]} == '1) << ST_BCAST);
      ex |= (32'(t == LT_VLAN) << ST_VLAN) | (32'(t == LT_PAUSE) << ST_PAUSE) | (32'(t >= TYPE_MIN) << ST_TYPE);
      if (eb < 0)
         cmpq("rx data", er, rq);
      if (eb < 0)
         chk("status", ex, st);
      else
         chk("status err", 32'h1 << eb, st & ((32'h1 << eb) | 32'h1));
      ngood += (eb < 0);
      nbad += (eb >= 0);
   endtask
   initial
   begin
      void'($urandom(32'h721A));
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      foreach (ra[i])
      begin
         apb(1'b0, ra[i], 32'h0, rdw, erw);
         chk("reg reset", re[i], rdw);
         chk("slverr", 32'(i == 4), 32'(erw));
      end
      apb(1'b1, REG_STATUS_OFS, 32'hFFFFFFFF, rdw, erw);
      apb(1'b1, REG_CTRL_OFS, 32'hFFFFFFFF, rdw, erw);
      apb(1'b0, REG_CTRL_OFS, 32'h0, rdw, erw);
      chk("ctrl", 32'h7F, rdw);
      apb(1'b0, REG_STATUS_OFS, 32'h0, rdw, erw);
      chk("status ro", 32'h0, rdw);
      for (int j = 0; j < 16; j++)
      begin
         n = (j < 4) ? (j == 0 ? 0 : 44 + j) : $urandom_range(0, 80);
         lt = (j % 5 == 0) ? 16'(n) : (j == 9 ? 16'($urandom_range(1536, 65535)) : lts[j % 5]);
         run(7'h00, mkf(j % 3, lt, n), -1);
      end
      run(7'h08, mkf(0, 16'h0800, 10), -1);
      run(7'h08, mkf(1, 16'h000A, 10), -1);
      run(7'h02, mkf(0, 16'h0014, 20), -1);
      run(7'h05, mkf(2, 16'h0800, 30), -1);
      run(7'h10, mkf(0, 16'h0014, 20), -1);
      run(7'h10, mkf(0, 16'h0014, 50), ST_LEN_ERR);
      cor <= 1'b1;
      run(7'h00, mkf(0, 16'h0800, 50), ST_FCS_ERR);
      cor <= 1'b0;
      apb(1'b1, REG_MAXLEN_OFS, 32'h0000005E, rdw, erw);
      run(7'h00, mkf(0, 16'h0800, 76), -1);
      run(7'h00, mkf(0, 16'h0800, 77), ST_TOO_LONG);
      run(7'h20, mkf(0, LT_VLAN, 80), -1);
      run(7'h20, mkf(0, LT_VLAN, 81), ST_TOO_LONG);
      run(7'h40, mkf(1, 16'h0800, 200), -1);
      apb(1'b0, REG_COUNT_OFS, 32'h0, rdw, erw);
      chk("count", {16'(nbad), 16'(ngood)}, rdw);
      apb(1'b1, REG_COUNT_OFS, 32'h0, rdw, erw);
      apb(1'b0, REG_COUNT_OFS, 32'h0, rdw, erw);
      chk("count clear", 32'h0, rdw);
      results();
   end
endmodule
